// ==== hdl/card_reader_consts.svh ====
// Offsets, field positions, fixed values and command codes of the card reader header
`ifndef CARD_READER_CONSTS_SVH
`define CARD_READER_CONSTS_SVH

// ----------------------------------------------------------------
// Configuration offsets (byte offsets, dword decoded)
// ----------------------------------------------------------------
`define OFF_TENURE_LINE 8'h0C
`define OFF_HEADER_SELF_TEST 8'h0E
`define OFF_WINDOW_BASE 8'h10
`define OFF_BOARD_VENDOR 8'h2C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TENURE_MSB 15
`define TENURE_LSB 8
`define LINE_MSB 7
`define LINE_LSB 0
`define HEADER_MULTI_BIT 7
`define WINDOW_ADDR_LSB 12

// ----------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------
`define TENURE_RESET 8'h00
`define LINE_RESET 8'h00
`define SELF_TEST_VALUE 8'h00
`define HEADER_FORMAT 7'h00
`define WINDOW_BASE_RESET 20'h00000
`define WINDOW_LOW_VALUE 12'h000
`define BOARD_VENDOR_RESET 16'h0000
`define UNMAPPED_READ 32'h00000000
`define UPPER_HALF_ZERO 16'h0000
`define BURST_NONE 8'h00

// ----------------------------------------------------------------
// Master command codes that use the line length
// ----------------------------------------------------------------
`define CMD_MEM_READ_MULTIPLE 4'hC
`define CMD_MEM_READ_LINE 4'hE
`define CMD_MEM_WRITE_INVALIDATE 4'hF

`endif

// ==== hdl/card_reader_pci_config_header.sv ====
// Configuration header slice of the card reader function with tenure control
//
// Overview of operation
// [RULE_01] Host-written 8-bit tenure limit counted while mastering
// [RULE_02] Tenure count restarts at zero on FRAME
// [RULE_03] Expired tenure ends transaction once GNT drops
// [RULE_04] Line length applied to line-based memory commands
// [RULE_05] Self-test byte always reads zero
// [RULE_06] Header byte standard, top bit shows multifunction
// [RULE_07] Host writes base address bits 31 to 12
// [RULE_08] Base bits 11 to 4 read zero
// [RULE_09] Prefetch flag reads zero
// [RULE_10] Base bits 2 and 1 read zero
// [RULE_11] Space kind bit zero, memory space
// [RULE_12] Board-vendor word read-only, loaded from EEPROM
// [RULE_13] Board-vendor word writable via subsystem access
// [RULE_14] Board-vendor word cleared only by power reset
// [RULE_15] Writes to fixed bits are ignored
`timescale 1ns/1ps
`include "card_reader_consts.svh"

module card_reader_pci_config_header
(
  input wire logic sys_clk, // System clock, 10 MHz
  input wire logic reset, // Async bus reset, active high
  input wire logic global_power_reset, // Async power-on reset, active high
  input wire logic cfg_rd, // Config read strobe
  input wire logic cfg_wr, // Config write strobe
  input wire logic [7:0] cfg_addr, // Config byte address
  input wire logic [3:0] cfg_be, // Config byte enables
  input wire logic [31:0] cfg_wdata, // Config write data
  input wire logic multifunction_strap, // Device has several functions
  input wire logic eeprom_id_load, // EEPROM loader strobe
  input wire logic [15:0] eeprom_id_data, // EEPROM board-vendor word
  input wire logic subsys_wr, // Subsystem access write strobe
  input wire logic [15:0] subsys_wdata, // Subsystem access word
  input wire logic frame_start, // Function drives FRAME as initiator
  input wire logic master_active, // Master transaction in progress
  input wire logic gnt_n, // Bus grant, active low
  input wire logic [3:0] master_cmd, // Command being issued
  output logic [31:0] cfg_rdata, // Config read data
  output logic cfg_rd_valid, // Read data valid
  output logic [7:0] tenure_limit, // Tenure limit setting
  output logic [7:0] line_length_setting, // Line length setting
  output logic [31:0] window_base, // Memory window base
  output logic [15:0] board_vendor_id, // Board-vendor word
  output logic multi_func, // Captured multifunction strap
  output logic tenure_expired, // Tenure counter expired
  output logic master_stop, // Terminate current transaction
  output logic [7:0] burst_line_length // Line length for this command
);

  logic strap_taken;
  logic header_multi;
  logic [19:0] window_addr;
  card_reader_pkg::byte_t tenure_count;
  logic [31:0] next_rdata;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] offset);
    dword_hit = (addr[7:2] == offset[7:2]);
  endfunction

  function automatic logic is_line_cmd(input card_reader_pkg::bus_cmd_t cmd);
    is_line_cmd = (cmd == `CMD_MEM_READ_MULTIPLE) || (cmd == `CMD_MEM_READ_LINE)
      || (cmd == `CMD_MEM_WRITE_INVALIDATE);
  endfunction

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      strap_taken <= 1'b0;
      multi_func <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap_taken <= 1'b1;
      multi_func <= multifunction_strap; // RULE_06
    end
  end

  // Read in the capture cycle still sees the strap
  assign header_multi = strap_taken ? multi_func : multifunction_strap; // RULE_06

  // ----------------------------------------------------------------
  // Tenure limit and line length
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      tenure_limit <= `TENURE_RESET;
      line_length_setting <= `LINE_RESET;
    end
    else if (cfg_wr && dword_hit(cfg_addr, `OFF_TENURE_LINE)) // RULE_15
    begin
      if (cfg_be[1])
      begin
        tenure_limit <= cfg_wdata[`TENURE_MSB:`TENURE_LSB]; // RULE_01
      end
      if (cfg_be[0])
      begin
        line_length_setting <= cfg_wdata[`LINE_MSB:`LINE_LSB]; // RULE_04
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory window base, only the upper twenty bits are storage
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      window_addr <= `WINDOW_BASE_RESET;
    end
    else if (cfg_wr && dword_hit(cfg_addr, `OFF_WINDOW_BASE))
    begin
      if (cfg_be[1])
      begin
        window_addr[3:0] <= cfg_wdata[15:12]; // RULE_07
      end
      if (cfg_be[2])
      begin
        window_addr[11:4] <= cfg_wdata[23:16]; // RULE_07
      end
      if (cfg_be[3])
      begin
        window_addr[19:12] <= cfg_wdata[31:24]; // RULE_07
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      window_base <= 32'h00000000;
    end
    else
    begin
      window_base <= {window_addr, `WINDOW_LOW_VALUE}; // RULE_08
    end
  end

  // ----------------------------------------------------------------
  // Board-vendor word, kept across bus reset
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge global_power_reset)
  begin
    if (global_power_reset)
    begin
      board_vendor_id <= `BOARD_VENDOR_RESET; // RULE_14
    end
    else if (subsys_wr)
    begin
      board_vendor_id <= subsys_wdata; // RULE_13
    end
    else if (eeprom_id_load)
    begin
      board_vendor_id <= eeprom_id_data; // RULE_12
    end
  end

  // ----------------------------------------------------------------
  // Config read path
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = `UNMAPPED_READ;
    if (dword_hit(cfg_addr, `OFF_TENURE_LINE))
    begin
      next_rdata = {`SELF_TEST_VALUE, header_multi, `HEADER_FORMAT, // RULE_05 RULE_06
        tenure_limit, line_length_setting};
    end
    else if (dword_hit(cfg_addr, `OFF_WINDOW_BASE))
    begin
      next_rdata = {window_addr, `WINDOW_LOW_VALUE}; // RULE_08 RULE_09 RULE_10 RULE_11
    end
    else if (dword_hit(cfg_addr, `OFF_BOARD_VENDOR))
    begin
      next_rdata = {`UPPER_HALF_ZERO, board_vendor_id};
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cfg_rdata <= `UNMAPPED_READ;
      cfg_rd_valid <= 1'b0;
    end
    else
    begin
      cfg_rd_valid <= cfg_rd;
      if (cfg_rd)
      begin
        cfg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Tenure counting and termination
  // ----------------------------------------------------------------
  tenure_counter u_tenure
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .tenure_limit(tenure_limit),
    .frame_start(frame_start),
    .master_active(master_active),
    .tenure_count(tenure_count),
    .tenure_expired(tenure_expired)
  );

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      master_stop <= 1'b0;
    end
    else
    begin
      master_stop <= master_active && tenure_expired && gnt_n && !frame_start; // RULE_03
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      burst_line_length <= `BURST_NONE;
    end
    else if (is_line_cmd(master_cmd))
    begin
      burst_line_length <= line_length_setting; // RULE_04
    end
    else
    begin
      burst_line_length <= `BURST_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_TENURE_WRITE: assert property ( // RULE_01
    @(posedge sys_clk) disable iff (reset)
    (cfg_wr && cfg_be[1] && dword_hit(cfg_addr, `OFF_TENURE_LINE))
      |=> tenure_limit == $past(cfg_wdata[15:8])
  ) else $error("tenure limit not written");

  AST_TENURE_RESTART: assert property ( // RULE_02
    @(posedge sys_clk) disable iff (reset)
    frame_start |=> tenure_count == 8'h00 && !tenure_expired
  ) else $error("tenure count not restarted on frame");

  AST_STOP_ON_GNT: assert property ( // RULE_03
    @(posedge sys_clk) disable iff (reset)
    (master_active && tenure_expired && gnt_n && !frame_start) |=> master_stop
  ) else $error("expired transaction not ended after grant loss");

  AST_NO_EARLY_STOP: assert property ( // RULE_03
    @(posedge sys_clk) disable iff (reset)
    master_stop |-> $past(tenure_expired) && $past(gnt_n) && $past(master_active)
  ) else $error("transaction ended without cause");

  AST_LINE_APPLY: assert property ( // RULE_04
    @(posedge sys_clk) disable iff (reset)
    is_line_cmd(master_cmd) |=> burst_line_length == $past(line_length_setting)
  ) else $error("line length not applied");

  AST_LINE_ONLY: assert property ( // RULE_04
    @(posedge sys_clk) disable iff (reset)
    !is_line_cmd(master_cmd) |=> burst_line_length == 8'h00
  ) else $error("line length applied to other command");

  AST_SELF_TEST_ZERO: assert property ( // RULE_05
    @(posedge sys_clk) disable iff (reset)
    (cfg_rd && dword_hit(cfg_addr, `OFF_TENURE_LINE)) |=> cfg_rd_valid && cfg_rdata[31:24] == 8'h00
  ) else $error("self-test byte not zero");

  AST_HEADER_BYTE: assert property ( // RULE_06
    @(posedge sys_clk) disable iff (reset)
    (cfg_rd && dword_hit(cfg_addr, `OFF_TENURE_LINE)) |=> cfg_rdata[23:16] == {multi_func, 7'h00}
  ) else $error("header byte wrong");

  AST_WINDOW_WRITE: assert property ( // RULE_07
    @(posedge sys_clk) disable iff (reset)
    (cfg_wr && cfg_be == 4'hF && dword_hit(cfg_addr, `OFF_WINDOW_BASE))
      |=> ##1 window_base[31:12] == $past(cfg_wdata[31:12], 2)
  ) else $error("window base not written");

  AST_WINDOW_LOW_ZERO: assert property ( // RULE_08
    @(posedge sys_clk) disable iff (reset)
    (cfg_rd && dword_hit(cfg_addr, `OFF_WINDOW_BASE)) |=> cfg_rdata[11:0] == 12'h000 // RULE_10
  ) else $error("window low bits not zero");

  AST_WINDOW_KIND: assert property ( // RULE_11
    @(posedge sys_clk) disable iff (reset)
    window_base[3:0] == 4'h0 // RULE_09
  ) else $error("window flags not zero");

  AST_VENDOR_RO: assert property ( // RULE_12
    @(posedge sys_clk) disable iff (global_power_reset)
    (!subsys_wr && !eeprom_id_load) |=> $stable(board_vendor_id)
  ) else $error("board-vendor word changed without load");

  AST_VENDOR_SUBSYS: assert property ( // RULE_13
    @(posedge sys_clk) disable iff (global_power_reset)
    subsys_wr |=> board_vendor_id == $past(subsys_wdata)
  ) else $error("subsystem write not taken");

  AST_VENDOR_KEEP: assert property ( // RULE_14
    @(posedge sys_clk) disable iff (global_power_reset)
    (reset && !subsys_wr && !eeprom_id_load) |=> $stable(board_vendor_id)
  ) else $error("board-vendor word disturbed by bus reset");

  AST_FIXED_IGNORED: assert property ( // RULE_15
    @(posedge sys_clk) disable iff (reset)
    (strap_taken && cfg_wr && dword_hit(cfg_addr, `OFF_TENURE_LINE)) |=> $stable(multi_func)
  ) else $error("fixed header bit changed by write");

endmodule

// ==== hdl/card_reader_pkg.sv ====
// Types shared by the card reader header logic
package card_reader_pkg;

  typedef enum logic [1:0]
  {
    TENURE_IDLE = 2'b00,
    TENURE_COUNT = 2'b01,
    TENURE_EXPIRED = 2'b10
  } tenure_state_e;

  typedef logic [7:0] byte_t;
  typedef logic [3:0] bus_cmd_t;

endpackage

// ==== hdl/tenure_counter.sv ====
// Bus tenure counter for the card reader bus master
`timescale 1ns/1ps
`include "card_reader_consts.svh"

module tenure_counter
(
  input wire logic sys_clk, // System clock
  input wire logic reset, // Async reset, active high
  input wire card_reader_pkg::byte_t tenure_limit, // Tenure limit in clocks
  input wire logic frame_start, // Function asserts FRAME
  input wire logic master_active, // Function owns the bus
  output card_reader_pkg::byte_t tenure_count, // Current count
  output logic tenure_expired // Limit reached
);

  card_reader_pkg::tenure_state_e state;

  // ----------------------------------------------------------------
  // Counter and state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= card_reader_pkg::TENURE_IDLE;
      tenure_count <= 8'h00;
      tenure_expired <= 1'b0;
    end
    else if (frame_start)
    begin
      state <= card_reader_pkg::TENURE_COUNT; // RULE_02
      tenure_count <= 8'h00; // RULE_02
      tenure_expired <= 1'b0;
    end
    else
    begin
      case (state)
        card_reader_pkg::TENURE_IDLE:
        begin
          tenure_expired <= 1'b0;
        end
        card_reader_pkg::TENURE_COUNT:
        begin
          if (!master_active)
          begin
            state <= card_reader_pkg::TENURE_IDLE;
          end
          else if (tenure_count == tenure_limit)
          begin
            state <= card_reader_pkg::TENURE_EXPIRED; // RULE_01
            tenure_expired <= 1'b1; // RULE_01
          end
          else
          begin
            tenure_count <= 8'(tenure_count + 8'h01); // RULE_01
          end
        end
        card_reader_pkg::TENURE_EXPIRED:
        begin
          if (!master_active)
          begin
            state <= card_reader_pkg::TENURE_IDLE;
            tenure_expired <= 1'b0;
          end
        end
        default:
        begin
          state <= card_reader_pkg::TENURE_IDLE;
          tenure_expired <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_EXPIRE_AT_LIMIT: assert property ( // RULE_01
    @(posedge sys_clk) disable iff (reset)
    (state == card_reader_pkg::TENURE_COUNT && master_active && !frame_start
      && tenure_count == tenure_limit) |=> tenure_expired
  ) else $error("tenure did not expire at its limit");

  AST_NO_EARLY_EXPIRE: assert property ( // RULE_01
    @(posedge sys_clk) disable iff (reset)
    $rose(tenure_expired) |-> $past(tenure_count) == $past(tenure_limit)
  ) else $error("tenure expired before its limit");

endmodule

// ==== testbench/bus_arbiter_model.sv ====
// Behavioural arbiter and initiator sequencer facing the tenure logic
`timescale 1ns/1ps

module bus_arbiter_model
(
  input wire logic sys_clk, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic master_stop, // Stop request from the block
  output logic frame_start, // FRAME pulse as initiator
  output logic master_active, // Transfer in progress
  output logic gnt_n, // Grant, active low
  output logic [3:0] master_cmd // Command on the bus
);
  // ----------------------------------------------------------------
  // Sequencing calls, entered just after a falling edge
  // ----------------------------------------------------------------
  task automatic begin_transfer(input logic [3:0] cmd);
    frame_start = 1'b1;
    master_active = 1'b1;
    gnt_n = 1'b0;
    master_cmd = cmd;
    @(negedge sys_clk);
    frame_start = 1'b0;
  endtask

  task automatic set_cmd(input logic [3:0] cmd);
    master_cmd = cmd;
  endtask

  task automatic release_grant();
    gnt_n = 1'b1;
  endtask

  initial
  begin
    frame_start = 1'b0;
    master_active = 1'b0;
    gnt_n = 1'b1;
    master_cmd = 4'h0;
  end

  // ----------------------------------------------------------------
  // Transfer ends once the block asks for it; released command inverts
  // ----------------------------------------------------------------
  always @(negedge sys_clk)
  begin
    if (reset === 1'b0 && master_stop === 1'b1 && master_active === 1'b1)
    begin
      master_active = 1'b0;
      master_cmd = ~master_cmd;
    end
  end
endmodule

// ==== testbench/card_reader_pci_config_header_tb_top.sv ====
// Self-checking bench for the card reader configuration header slice
`timescale 1ns/1ps

`define CHECK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end

module card_reader_pci_config_header_tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic global_power_reset = 1'b1;
  logic cfg_rd = 1'b0;
  logic cfg_wr = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h00000000;
  logic multifunction_strap = 1'b1;
  logic eeprom_id_load = 1'b0;
  logic [15:0] eeprom_id_data = 16'h0000;
  logic subsys_wr = 1'b0;
  logic [15:0] subsys_wdata = 16'h0000;
  logic frame_start, master_active, gnt_n;
  logic [3:0] master_cmd;
  logic [31:0] cfg_rdata, window_base;
  logic cfg_rd_valid, multi_func, tenure_expired, master_stop;
  logic [7:0] tenure_limit, line_length_setting, burst_line_length;
  logic [15:0] board_vendor_id;
  logic [31:0] rd;
  int err_count = 0;
  int n_compared = 0;

  always #50 sys_clk = ~sys_clk;

  card_reader_pci_config_header dut (.sys_clk(sys_clk), .reset(reset), .global_power_reset(global_power_reset),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .multifunction_strap(multifunction_strap), .eeprom_id_load(eeprom_id_load), .eeprom_id_data(eeprom_id_data),
    .subsys_wr(subsys_wr), .subsys_wdata(subsys_wdata), .frame_start(frame_start), .master_active(master_active),
    .gnt_n(gnt_n), .master_cmd(master_cmd), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
    .tenure_limit(tenure_limit), .line_length_setting(line_length_setting), .window_base(window_base),
    .board_vendor_id(board_vendor_id), .multi_func(multi_func), .tenure_expired(tenure_expired),
    .master_stop(master_stop), .burst_line_length(burst_line_length));

  bus_arbiter_model partner (.sys_clk(sys_clk), .reset(reset), .master_stop(master_stop),
    .frame_start(frame_start), .master_active(master_active), .gnt_n(gnt_n), .master_cmd(master_cmd));

  // ----------------------------------------------------------------
  // Closing report
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Configuration cycles, driven from a falling edge
  // ----------------------------------------------------------------
  task automatic cfg_write(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] data);
    cfg_wr = 1'b1;
    cfg_addr = addr;
    cfg_be = be;
    cfg_wdata = data;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
    cfg_wdata = ~data;
    @(negedge sys_clk);
  endtask

  task automatic cfg_read(input logic [7:0] addr, output logic [31:0] data);
    int k;
    cfg_rd = 1'b1;
    cfg_addr = addr;
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    k = 0;
    while (cfg_rd_valid !== 1'b1 && k < 4)
    begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 4)
    begin
      err_count++;
      test_done();
    end
    data = cfg_rdata;
    @(negedge sys_clk);
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    cfg_read(`OFF_TENURE_LINE, rd);
    `CHECK("dword 0C at reset", {8'h00, 1'b1, 7'h00, 16'h0000}, rd)
    `CHECK("strap captured", 1'b1, multi_func)
    cfg_read(`OFF_WINDOW_BASE, rd);
    `CHECK("base at reset", 32'h00000000, rd)
    cfg_read(`OFF_BOARD_VENDOR, rd);
    `CHECK("vendor at reset", 32'h00000000, rd)
  endtask

  task automatic test_tenure_line_regs();
    cfg_write(`OFF_TENURE_LINE, 4'hF, 32'hFFFFA55A);
    cfg_read(`OFF_TENURE_LINE, rd);
    `CHECK("dword 0C full write", {8'h00, 1'b1, 7'h00, 16'hA55A}, rd)
    `CHECK("tenure limit", 8'hA5, tenure_limit)
    `CHECK("line length", 8'h5A, line_length_setting)
    cfg_write(`OFF_TENURE_LINE, 4'h1, 32'hFFFFFF3C);
    cfg_write(`OFF_TENURE_LINE, 4'h2, 32'hFFFF71FF);
    cfg_read(`OFF_TENURE_LINE, rd);
    `CHECK("dword 0C byte writes", {8'h00, 1'b1, 7'h00, 16'h713C}, rd)
  endtask

  task automatic test_window_base();
    cfg_write(`OFF_WINDOW_BASE, 4'hF, 32'hFFFFFFFF);
    cfg_read(`OFF_WINDOW_BASE, rd);
    `CHECK("base all ones", 32'hFFFFF000, rd)
    `CHECK("base port", 32'hFFFFF000, window_base)
    cfg_write(`OFF_WINDOW_BASE, 4'h2, 32'h0000ABFF);
    cfg_read(`OFF_WINDOW_BASE, rd);
    `CHECK("base byte one", 32'hFFFFA000, rd)
  endtask

  task automatic test_vendor();
    cfg_write(`OFF_BOARD_VENDOR, 4'hF, 32'hFFFFFFFF);
    cfg_read(`OFF_BOARD_VENDOR, rd);
    `CHECK("vendor after config write", 32'h00000000, rd)
    eeprom_id_data = 16'h1234;
    eeprom_id_load = 1'b1;
    wait_cycles(1);
    eeprom_id_load = 1'b0;
    cfg_read(`OFF_BOARD_VENDOR, rd);
    `CHECK("vendor from loader", 32'h00001234, rd)
    subsys_wdata = 16'h5678;
    subsys_wr = 1'b1;
    wait_cycles(1);
    subsys_wr = 1'b0;
    cfg_read(`OFF_BOARD_VENDOR, rd);
    `CHECK("vendor from subsystem path", 32'h00005678, rd)
    eeprom_id_data = 16'h1111;
    subsys_wdata = 16'h2222;
    eeprom_id_load = 1'b1;
    subsys_wr = 1'b1;
    wait_cycles(1);
    eeprom_id_load = 1'b0;
    subsys_wr = 1'b0;
    cfg_read(8'h40, rd);
    `CHECK("unmapped read", 32'h00000000, rd)
    `CHECK("vendor port", 16'h2222, board_vendor_id)
    multifunction_strap = 1'b0;
    reset = 1'b1;
    wait_cycles(3);
    reset = 1'b0;
    cfg_read(`OFF_BOARD_VENDOR, rd);
    `CHECK("vendor through bus reset", 32'h00002222, rd)
    cfg_read(`OFF_TENURE_LINE, rd);
    `CHECK("single function header", 32'h00000000, rd)
    global_power_reset = 1'b1;
    wait_cycles(2);
    global_power_reset = 1'b0;
    cfg_read(`OFF_BOARD_VENDOR, rd);
    `CHECK("vendor after power reset", 32'h00000000, rd)
  endtask

  task automatic test_tenure(input logic [7:0] lim);
    int k;
    cfg_write(`OFF_TENURE_LINE, 4'h2, {16'h0000, lim, 8'h00});
    partner.begin_transfer(4'h7);
    if (lim > 8'h03)
    begin
      wait_cycles(1);
      partner.begin_transfer(4'h7);
    end
    k = 1;
    while (tenure_expired !== 1'b1 && k < 40)
    begin
      @(negedge sys_clk);
      k++;
    end
    if (tenure_expired !== 1'b1)
    begin
      err_count++;
      test_done();
    end
    `CHECK("expiry edge count in range", 1'b1, (k >= lim + 1 && k <= lim + 2))
    `CHECK("no stop while granted", 1'b0, master_stop)
    partner.release_grant();
    k = 0;
    while (master_stop !== 1'b1 && k < 3)
    begin
      @(negedge sys_clk);
      k++;
    end
    if (master_stop !== 1'b1)
    begin
      err_count++;
      test_done();
    end
    `CHECK("stop after grant drop", 1'b1, master_stop)
    wait_cycles(3);
    `CHECK("stop released", 1'b0, master_stop)
    `CHECK("expiry cleared", 1'b0, tenure_expired)
  endtask

  task automatic test_burst();
    logic [3:0] cmds [5];
    logic [7:0] exp;
    cmds = '{4'hC, 4'hE, 4'hF, 4'h7, 4'hD};
    cfg_write(`OFF_TENURE_LINE, 4'h1, 32'h00000077);
    foreach (cmds[i])
    begin
      partner.set_cmd(cmds[i]);
      wait_cycles(2);
      exp = (i < 3) ? 8'h77 : 8'h00;
      `CHECK("burst line length", exp, burst_line_length)
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    wait_cycles(20);
    reset = 1'b0;
    global_power_reset = 1'b0;
    test_reset_values();
    test_tenure_line_regs();
    test_window_base();
    test_tenure(8'h00);
    test_tenure(8'h05);
    test_burst();
    test_vendor();
    test_done();
  end
endmodule
